// *** pkg/i2c_bc_pkg.sv ***
/*
  Constants for the frame bit counter and interrupt enable block:
  register byte offsets, field positions, reset values and bus answers.
  Assumes a 32-bit AXI4-Lite register bus with 8-bit wide registers.
*/
`default_nettype none
package i2c_bc_pkg;
  localparam int ADDR_W = 8;

  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_TX_BUF    = 8'h0C;
  localparam logic [7:0] OFS_RX_BUF    = 8'h10;
  localparam logic [7:0] OFS_EVT       = 8'h14;
  localparam logic [7:0] OFS_EVT_CLR   = 8'h18;
  localparam logic [7:0] OFS_EVT_EN    = 8'h1C;
  localparam logic [7:0] OFS_CTRL      = 8'h20;

  localparam int MODE_WAIT_BIT = 6;
  localparam int MODE_WP_BIT   = 3;
  localparam int EN_TX_EMPTY   = 7;
  localparam int EN_TX_END     = 6;
  localparam int EN_RX_FULL    = 5;
  localparam int ST_TX_EMPTY   = 7;
  localparam int ST_TX_END     = 6;
  localparam int ST_RX_FULL    = 5;
  localparam int CTRL_TX_BIT   = 0;
  localparam int EVT_FRAME     = 0;
  localparam int EVT_LOAD      = 1;
  localparam int EVT_RECV      = 2;
  localparam int EVT_W         = 3;

  localparam logic [2:0] LEN_CODE_RESET = 3'h0;
  localparam logic [3:0] LEN_NINE       = 4'h9;
  localparam logic [1:0] MODE_ONES      = 2'h3;
  localparam logic [2:0] EN_RESET       = 3'h0;
  localparam logic [7:0] BYTE_RESET     = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** core/i2c_bit_counter_irq_enable.sv ***
/*
  Frame bit counter, transmit/receive flags and interrupt enables of an
  I2C bus interface, with an AXI4-Lite register slave.
  Assumes scl and sda arrive asynchronously from the bus pins and that the
  testbench resolves the open-drain sda wire from sda_oe and its own drive; sda_out is not used.
*/
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Count code 000 is 9 bits, else code+1
// - Count reads back bits still outstanding
// - One acknowledge bit follows every data frame
// - Count code returns to 000 after frame
// - Transmit-empty request needs flag and enable bit
// - Transmit-end set at ack clock while empty
// - Clearing flag or enable withdraws transmit-end request
// - Receive-full set when received byte moves over
// - Clearing flag or enable withdraws receive-full request
// - Transmit-empty set when buffer moves to shift
module i2c_bit_counter_irq_enable
  import i2c_bc_pkg::*;
(
  input  wire logic              aclk,          // Bus clock, 50 MHz
  input  wire logic              aresetn,       // Synchronous reset, low
  input  wire logic [ADDR_W-1:0] awaddr,        // Write address
  input  wire logic              awvalid,       // Write address valid
  output logic                   awready,       // Write address ready
  input  wire logic [31:0]       wdata,         // Write data
  input  wire logic [3:0]        wstrb,         // Write byte strobes
  input  wire logic              wvalid,        // Write data valid
  output logic                   wready,        // Write data ready
  output logic [1:0]             bresp,         // Write response
  output logic                   bvalid,        // Write response valid
  input  wire logic              bready,        // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,        // Read address
  input  wire logic              arvalid,       // Read address valid
  output logic                   arready,       // Read address ready
  output logic [31:0]            rdata,         // Read data
  output logic [1:0]             rresp,         // Read response
  output logic                   rvalid,        // Read data valid
  input  wire logic              rready,        // Read data ready
  input  wire logic              scl_in,        // Serial clock pin level
  input  wire logic              sda_in,        // Serial data pin level
  output logic                   sda_out,       // Serial data drive level
  output logic                   sda_oe,        // Serial data drive enable
  output logic                   tx_empty_irq,  // Transmit-empty request
  output logic                   tx_end_irq,    // Transmit-end request
  output logic                   rx_full_irq,   // Receive-full request
  output logic                   irq            // Event interrupt
);

  logic [ADDR_W-1:0] wa;
  logic [7:0]        wd;
  logic              wbyte;
  logic              aw_got;
  logic              w_got;
  logic              wr_done, wr_en;
  logic              scl_meta, scl_sync, scl_prev;
  logic              sda_meta, sda_sync;
  logic              scl_rise, scl_fall;
  logic [2:0]        code;
  logic [3:0]        rem;
  logic              wait_bit;
  logic              tx_mode;
  logic [2:0]        irq_en;
  logic              tx_buf_empty_flag, tx_end_flag, rx_buf_full_flag;
  logic [7:0]        tx_buf, rx_buf, shift;
  logic              tx_buf_full, shift_full;
  logic              load;
  logic              last_data, ack_rise;
  logic [EVT_W-1:0]  evt, evt_en, evt_set;
  logic [31:0]       next_rdata;
  logic              next_rmapped;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic [3:0] frame_total(input logic [2:0] c);
    frame_total = (c == 3'h0) ? LEN_NINE + 4'h1 : {1'b0, c} + 4'h2;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = a inside {OFS_MODE, OFS_IRQ_EN, OFS_STATUS, OFS_TX_BUF, OFS_RX_BUF,
                       OFS_EVT, OFS_EVT_CLR, OFS_EVT_EN, OFS_CTRL};
  endfunction

  // Write channel: address and data in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wa      <= '0;
      wd      <= BYTE_RESET;
      wbyte   <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        wa      <= {awaddr[ADDR_W-1:2], 2'b00};
        aw_got  <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd     <= wdata[7:0];
        wbyte  <= wstrb[0];
        w_got  <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_done) begin
        bvalid <= 1'b1;
        bresp  <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        aw_got  <= 1'b0;
        w_got   <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  assign wr_done = aw_got && w_got && !bvalid;
  assign wr_en   = wr_done && wbyte;  // Without byte 0 the write is answered, not applied

  // Read channel
  always_comb begin
    next_rdata   = 32'h0000_0000;
    next_rmapped = mapped({araddr[ADDR_W-1:2], 2'b00});
    unique case ({araddr[ADDR_W-1:2], 2'b00})
      OFS_MODE:    next_rdata[7:0] = {1'b0, wait_bit, MODE_ONES, 1'b1,
                                      (rem != 4'h0) ? rem[2:0] : code};
      OFS_IRQ_EN:  next_rdata[7:0] = {irq_en, 5'h00};
      OFS_STATUS:  next_rdata[7:0] = {tx_buf_empty_flag, tx_end_flag, rx_buf_full_flag, 5'h00};
      OFS_TX_BUF:  next_rdata[7:0] = tx_buf;
      OFS_RX_BUF:  next_rdata[7:0] = rx_buf;
      OFS_EVT:     next_rdata[EVT_W-1:0] = evt;
      OFS_EVT_EN:  next_rdata[EVT_W-1:0] = evt_en;
      OFS_CTRL:    next_rdata[CTRL_TX_BIT] = tx_mode;
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= next_rmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Pin synchronisers and serial clock edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
    end
  end

  assign scl_rise  = scl_sync && !scl_prev;
  assign scl_fall  = !scl_sync && scl_prev;
  assign last_data = scl_rise && (rem == 4'h2);
  assign ack_rise  = scl_rise && (rem == 4'h1);

  // Count code and remaining bits of the running frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code     <= LEN_CODE_RESET;
      rem      <= 4'h0;
      wait_bit <= 1'b0;
    end else begin
      if (wr_en && wa == OFS_MODE) begin
        wait_bit <= wd[MODE_WAIT_BIT];
        if (!wd[MODE_WP_BIT]) begin
          code <= wd[2:0];
        end
      end
      if (scl_rise) begin
        if (rem == 4'h0) begin
          rem <= frame_total(code) - 4'h1;
        end else begin
          rem <= rem - 4'h1;
        end
        if (rem == 4'h1) begin
          code <= LEN_CODE_RESET;
        end
      end
    end
  end

  // Control and enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en  <= EN_RESET;
      evt_en  <= '0;
      tx_mode <= 1'b0;
    end else if (wr_en) begin
      if (wa == OFS_IRQ_EN) begin
        irq_en <= wd[EN_TX_EMPTY:EN_RX_FULL];
      end
      if (wa == OFS_EVT_EN) begin
        evt_en <= wd[EVT_W-1:0];
      end
      if (wa == OFS_CTRL) begin
        tx_mode <= wd[CTRL_TX_BIT];
      end
    end
  end

  // Transmit buffer and shift register
  assign load = (rem == 4'h0) && !scl_rise && tx_mode && tx_buf_full && !shift_full;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf      <= BYTE_RESET;
      tx_buf_full <= 1'b0;
      shift       <= BYTE_RESET;
      shift_full  <= 1'b0;
      rx_buf      <= BYTE_RESET;
    end else begin
      if (load) begin
        shift       <= tx_buf;
        shift_full  <= 1'b1;
        tx_buf_full <= 1'b0;
      end
      if (wr_en && wa == OFS_TX_BUF) begin
        tx_buf      <= wd;
        tx_buf_full <= 1'b1;
      end
      if (scl_rise && rem != 4'h1) begin
        shift <= {shift[6:0], tx_mode ? 1'b1 : sda_sync};
      end
      if (last_data && !tx_mode) begin
        rx_buf <= {shift[6:0], sda_sync};
      end
      if (ack_rise) begin
        shift_full <= 1'b0;
      end
    end
  end

  // Status flags; a hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_empty_flag <= 1'b0;
      tx_end_flag       <= 1'b0;
      rx_buf_full_flag  <= 1'b0;
    end else begin
      if (wr_en && wa == OFS_STATUS) begin
        if (!wd[ST_TX_EMPTY]) tx_buf_empty_flag <= 1'b0;
        if (!wd[ST_TX_END]) tx_end_flag <= 1'b0;
        if (!wd[ST_RX_FULL]) rx_buf_full_flag <= 1'b0;
      end
      if (wr_en && wa == OFS_TX_BUF) begin
        tx_buf_empty_flag <= 1'b0;
        tx_end_flag       <= 1'b0;
      end
      if (load) tx_buf_empty_flag <= 1'b1;
      if (ack_rise && tx_buf_empty_flag) tx_end_flag <= 1'b1;
      if (last_data && !tx_mode) rx_buf_full_flag <= 1'b1;
    end
  end

  // Serial data drive, changed at scl falling edges and when the buffer moves to shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (scl_fall) begin
      if (rem == 4'h1) begin
        sda_oe <= !tx_mode;
      end else if (tx_mode && shift_full && rem != 4'h0) begin
        sda_oe <= !shift[7];
      end else begin
        sda_oe <= 1'b0;
      end
    end else if (load) begin
      sda_oe <= !tx_buf[7];
    end
  end

  // Interrupt requests and sticky event interrupt
  assign evt_set = {last_data && !tx_mode, load, ack_rise};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt          <= '0;
      irq          <= 1'b0;
      tx_empty_irq <= 1'b0;
      tx_end_irq   <= 1'b0;
      rx_full_irq  <= 1'b0;
    end else begin
      evt          <= (evt & ~((wr_en && wa == OFS_EVT_CLR) ? wd[EVT_W-1:0] : '0))
                      | evt_set;
      irq          <= |(evt & evt_en);
      tx_empty_irq <= tx_buf_empty_flag && irq_en[2];
      tx_end_irq   <= tx_end_flag && irq_en[1];
      rx_full_irq  <= rx_buf_full_flag && irq_en[0];
    end
  end

  chk_len_code_nine: assert property (
    scl_rise && rem == 4'h0 && code == 3'h0 |=> rem == 4'h9)
    else $error("Code zero did not give nine data bits");
  chk_len_code_max: assert property (
    scl_rise && rem == 4'h0 && code == 3'h7 |=> rem == 4'h8)
    else $error("Code seven did not give eight data bits");
  chk_count_readback: assert property (
    arvalid && arready && araddr == OFS_MODE && rem != 4'h0
    |=> rdata[2:0] == $past(rem[2:0]))
    else $error("Count read did not show outstanding bits");
  chk_ack_closes: assert property (
    ack_rise |=> rem == 4'h0 ##1 !ack_rise)
    else $error("Frame did not end after one ack bit");
  chk_code_reload: assert property (
    ack_rise |=> code == 3'h0)
    else $error("Count code not reloaded at frame end");
  chk_tx_empty_off: assert property (
    !irq_en[2] |=> !tx_empty_irq)
    else $error("Transmit-empty request while disabled");
  chk_tx_end_set: assert property (
    ack_rise && tx_buf_empty_flag |=> tx_end_flag ##1 (tx_end_irq == $past(irq_en[1])))
    else $error("Transmit end not flagged at ack clock");
  chk_tx_end_drop: assert property (
    !tx_end_flag || !irq_en[1] |=> !tx_end_irq)
    else $error("Transmit-end request not withdrawn");
  chk_rx_full_set: assert property (
    last_data && !tx_mode |=> rx_buf_full_flag && rx_buf == {$past(shift[6:0]), $past(sda_sync)})
    else $error("Receive-full not set on byte move");
  chk_rx_full_drop: assert property (
    !rx_buf_full_flag || !irq_en[0] |=> !rx_full_irq)
    else $error("Receive-full request not withdrawn");
  chk_protect_write: assert property (
    wr_en && wa == OFS_MODE && wd[MODE_WP_BIT] && !scl_rise |=> code == $past(code))
    else $error("Protected count write was taken");
  chk_load_empty: assert property (
    load |=> tx_buf_empty_flag && shift_full)
    else $error("Buffer move did not set transmit-empty");

  cov_rx_frame: cover property (last_data && !tx_mode ##[1:40] ack_rise);
  cov_tx_end: cover property (ack_rise && tx_buf_empty_flag);
  cov_short_frame: cover property (scl_rise && rem == 4'h0 && code == 3'h1);

endmodule

`default_nettype wire

// *** tb/i2c_bus_model.sv ***
/*
  Far side of the serial link: makes the serial clock only inside frames
  (160 ns period) and drives or releases the data line.
  Assumes a pull-up on sda and that the block's drive enable pulls it low.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_model (
  input  wire logic dev_oe,  // Block pulls sda low
  output logic      scl,     // Serial clock, low between frames
  output wire logic sda      // Resolved data wire
);
  logic       drv;
  logic       ack;
  logic       txm;
  logic [7:0] obyte;
  logic [7:0] got;
  int         nb;
  int         idx;

  // Open drain: any low drive wins, else the pull-up
  assign sda = (dev_oe || !drv) ? 1'b0 : 1'b1;

  initial begin
    scl = 1'b0;
    drv = 1'b1;
    ack = 1'b1;
    got = 8'h00;
  end

  task start(input int n, input logic [7:0] b, input logic t);
    nb = n;
    obyte = b;
    txm = t;
    idx = 0;
    got = 8'h00;
    ack = 1'b1;
  endtask

  // Receiving side acks low; sending side releases the line for the ack
  task pulses(input int k);
    #7;
    repeat (k) begin
      #20;
      drv = txm ? (idx != nb) : (idx >= nb || obyte[(nb - 1 - idx) % 8]);
      #80 scl = 1'b1;
      if (idx < 8) got = {got[6:0], sda};
      if (idx == nb) ack = sda;
      #60 scl = 1'b0;
      idx++;
    end
    if (idx > nb) begin
      #20 drv = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// *** tb/i2c_bit_counter_irq_enable_bench.sv ***
/*
  Self-checking bench for the frame bit counter and interrupt enable block.
  Assumes the bus model of i2c_bus_model.sv on the serial side.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_bit_counter_irq_enable_bench;
  import i2c_bc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sda_oe, scl, sda_out;
  logic        tx_empty_irq, tx_end_irq, rx_full_irq, irq;
  logic [7:0]  awaddr, araddr, v;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  wire         sda;
  int          error_cnt, n_tests, c, n;

  i2c_bit_counter_irq_enable uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .tx_empty_irq, .tx_end_irq, .rx_full_irq, .irq);
  i2c_bus_model model (.dev_oe(sda_oe), .scl(scl), .sda(sda));

  task stop_test;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task hang;
    error_cnt++;
    $display("mismatch handshake expected answer seen none");
    stop_test;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && !(bvalid && bready); i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    if (i == 50) hang;
    bready <= 1'b0;
    chk("bresp", {6'h0, RESP_OKAY}, {6'h0, bresp});
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] rs);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && !(rvalid && rready); i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    if (i == 50) hang;
    rready <= 1'b0;
    d = rdata[7:0];
    rs = rresp;
  endtask

  task rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a, v, r);
    chk(nm, e, v);
    chk("rresp", {6'h0, RESP_OKAY}, {6'h0, r});
  endtask

  // Order: transmit-empty, transmit-end, receive-full, event interrupt
  task ci(input logic [3:0] e);
    repeat (3) @(posedge aclk);
    chk("request lines", {4'h0, e}, {4'h0, tx_empty_irq, tx_end_irq, rx_full_irq, irq});
  endtask

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    error_cnt = 0;
    n_tests = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc("irq enable", OFS_IRQ_EN, 8'h00);
    rc("mode", OFS_MODE, 8'h38);
    chk("sda drive level", 8'h00, {7'h0, sda_out});
    ci(4'h0);
    rd(8'h24, v, r);
    chk("unmapped resp", {6'h0, RESP_SLVERR}, {6'h0, r});
    wr(OFS_MODE, 8'h4B);
    rc("protected code", OFS_MODE, 8'h78);
    wr(OFS_IRQ_EN, 8'h20);
    for (c = 0; c < 8; c++) begin
      n = (c == 0) ? 9 : c + 1;
      wr(OFS_MODE, {5'h00, c[2:0]});
      rc("code", OFS_MODE, {5'h07, c[2:0]});
      model.start(n, 8'hA5, 1'b0);
      model.pulses(2);
      rc("remaining", OFS_MODE, {5'h07, 3'(n - 1)});
      model.pulses(n - 1);
      chk("ack level", 8'h00, {7'h0, model.ack});
      rc("reload", OFS_MODE, 8'h38);
    end
    rc("rx buffer", OFS_RX_BUF, 8'hA5);
    ci(4'b0010);
    wr(OFS_IRQ_EN, 8'h00);
    ci(4'b0000);
    wr(OFS_IRQ_EN, 8'h20);
    ci(4'b0010);
    wr(OFS_STATUS, 8'hDF);
    ci(4'b0000);
    wr(OFS_CTRL, 8'h01);
    wr(OFS_IRQ_EN, 8'hE0);
    ci(4'b0000);
    wr(OFS_TX_BUF, 8'hC3);
    ci(4'b1000);
    model.start(9, 8'hFF, 1'b1);
    model.pulses(10);
    chk("sent byte", 8'hC3, model.got);
    ci(4'b1100);
    wr(OFS_IRQ_EN, 8'hA0);
    ci(4'b1000);
    wr(OFS_IRQ_EN, 8'hE0);
    ci(4'b1100);
    wr(OFS_STATUS, 8'hBF);
    ci(4'b1000);
    wr(OFS_IRQ_EN, 8'h60);
    ci(4'b0000);
    wstrb <= 4'hE;
    wr(OFS_IRQ_EN, 8'hE0);
    wstrb <= 4'hF;
    rc("strobe off", OFS_IRQ_EN, 8'h60);
    rc("status", OFS_STATUS, 8'h80);
    rc("events", OFS_EVT, 8'h07);
    wr(OFS_EVT_EN, 8'h01);
    ci(4'b0001);
    wr(OFS_EVT_EN, 8'h00);
    ci(4'b0000);
    wr(OFS_EVT_EN, 8'h07);
    wr(OFS_EVT_CLR, 8'h07);
    rc("events cleared", OFS_EVT, 8'h00);
    ci(4'b0000);
    stop_test;
  end
endmodule
`default_nettype wire
